// [rtl/sar_cfg.svh]
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH
// How it works
// - Mode select picks 7-bit or 10-bit addressing, each with or without start/stop irq.
// - Start/stop irq modes set the irq flag on start, restart and stop.
// - First byte after start is matched to own address; a match loads buffer, raises irq.
// - A mismatching first byte returns to idle silently.
// - 7-bit matching ignores the received read/write bit.
// - 10-bit high byte must be 11110, own bits 2..1, then zero, or one after a prior write match.
// - After an acked 10-bit high write byte, set update flag and hold SCL until address write.
// - 10-bit low byte compares all eight bits; mismatch still sets irq, update flag, hold.
// - Writing own address clears the update flag and releases that hold.
// - 10-bit read needs a prior full write match, then restart with high byte read.
// - A matching write address clears the read/write status, loads buffer, is acked.
// - Buffer full (unless overwrite enabled) or overflow set at address time gives a nack.
// - Every acked byte sets the irq flag; only software clears it.
// - With stretch enabled, SCL is held after each acked byte until release set.
// - A start sets the start-detected bit; irq only if start irq enabled or a start/stop irq mode is selected.
// - Reading the buffer clears the buffer-full flag.
// - A stop sets the stop-detected bit and puts the slave to idle.
// - Address or data hold sets irq and clears release after the eighth falling edge.
// - Under hold, software picks the ack value before releasing; it is driven in the slot.
// - The ack phase flag tells whether an irq came before or after the ack slot.
// - Irq is set at the ninth falling edge after an ack; after a nack only on a 10-bit low byte mismatch.
// - Hold plus stretch enable also stretches SCL after the ack slot.
// - Without any hold the ack is generated automatically.
// - SDA sampled on SCL rise, eight bits MSB first, ninth is the ack slot.
`define SAR_MODE_7 2'h0
`define SAR_MODE_10 2'h1
`define SAR_MODE_7_SP 2'h2
`define SAR_MODE_10_SP 2'h3
`define SAR_HI_PAT 5'h1E
`define SAR_OWN_RST 8'h00
`define SAR_BYTE_END 4'h8
`define SAR_ACK_END 4'h9
`endif

// [rtl/sar_pkg.sv]
package sar_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RECV = 2'h1,
    ST_ACK = 2'h3,
    ST_WAIT = 2'h2
  } sar_state_t;
  typedef enum logic [1:0] {
    K_HI = 2'h0,
    K_LO = 2'h1,
    K_DATA = 2'h2
  } sar_kind_t;
  typedef struct packed {
    logic [1:0] mode;
    logic stretch_enable;
    logic address_hold_enable;
    logic data_hold_enable;
    logic buffer_overwrite_enable;
    logic start_irq_en;
    logic stop_irq_en;
    logic ack_value_select;
  } sar_cfg_t;
  typedef struct packed {
    logic [7:0] shift_buffer;
    logic serial_port_irq_flag;
    logic buffer_full_flag;
    logic receive_overflow_flag;
    logic update_address_flag;
    logic clock_release_bit;
    logic ack_phase_flag;
    logic read_write;
    logic start_detected;
    logic stop_detected;
  } sar_status_t;
endpackage

// [rtl/sar_slave.sv]
`timescale 1ns/1ps
`include "sar_cfg.svh"
module sar_slave #(
  parameter int BYTE_BITS = 8
) (
  // Clocks and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_clk_in,
  // Bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Software side
  input wire sar_pkg::sar_cfg_t cfg_in,
  input wire logic [7:0] own_addr_in,
  input wire logic own_addr_wr_in,
  input wire logic clock_release_set_in,
  input wire logic irq_clear_in,
  input wire logic buf_read_in,
  input wire logic ovf_clear_in,
  output sar_pkg::sar_status_t status_out
);
  typedef struct packed {
    sar_pkg::sar_state_t state;
    sar_pkg::sar_kind_t kind;
    logic [3:0] cnt;
    logic [7:0] own_address_reg;
    logic sda_pull;
    logic scl_hold;
    logic upd_hold;
    logic sw_ack;
    logic prior;
    logic lo_miss;
    logic pin_low;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    sar_pkg::sar_status_t stat;
  } sar_regs_t;
  typedef struct packed {
    logic [7:0] shift;
  } sar_link_t;

  sar_regs_t r;
  sar_regs_t next_r;
  sar_link_t link;
  sar_link_t next_link;
  logic rise, fall, start_ev, stop_ev, ten, sp_mode, fall8, fall9;
  logic match, nack, hold, full_set, upd_set;
  logic [7:0] rx;

  generate
    if (BYTE_BITS != 8) begin : g_chk
      $error("sar_slave serves eight-bit bytes only");
    end
  endgenerate

  function automatic logic addr_match(input sar_pkg::sar_kind_t kind, input logic ten_bit,
                                      input logic [7:0] own, input logic [7:0] b,
                                      input logic prior);
    logic hi;
    hi = (b[7:3] == `SAR_HI_PAT) && (b[2:1] == own[2:1]);
    if (kind == sar_pkg::K_DATA)
      addr_match = 1'b1;
    else if (!ten_bit)
      addr_match = (b[7:1] == own[7:1]);
    else if (kind == sar_pkg::K_LO)
      addr_match = (b == own);
    else
      addr_match = hi && (!b[0] || prior);
  endfunction

  // Link side: SDA taken on each SCL rise, MSB first; address and data alike, held
  // stable from the eighth rise until the ninth, while the system side reads it after the eighth fall
  always_comb begin
    next_link = link;
    next_link.shift = {link.shift[6:0], sda_in};
  end

  always_ff @(posedge scl_clk_in) begin
    link <= next_link;
  end

  // System side
  always_comb begin
    next_r = r;
    next_r.scl_s = {r.scl_s[1:0], scl_in};
    next_r.sda_s = {r.sda_s[1:0], sda_in};
    rise = r.scl_s[1] && !r.scl_s[2];
    fall = !r.scl_s[1] && r.scl_s[2];
    start_ev = r.scl_s[1] && r.scl_s[2] && r.sda_s[2] && !r.sda_s[1];
    stop_ev = r.scl_s[1] && r.scl_s[2] && !r.sda_s[2] && r.sda_s[1];
    ten = cfg_in.mode[0];
    sp_mode = cfg_in.mode[1];
    fall8 = fall && (r.state == sar_pkg::ST_RECV) && (r.cnt == `SAR_BYTE_END);
    fall9 = fall && (r.state == sar_pkg::ST_ACK) && (r.cnt == `SAR_ACK_END);
    rx = link.shift;
    match = addr_match(r.kind, ten, r.own_address_reg, rx, r.prior);
    nack = !match || r.stat.receive_overflow_flag ||
           (r.stat.buffer_full_flag && !cfg_in.buffer_overwrite_enable);
    hold = match && ((r.kind == sar_pkg::K_DATA) ? cfg_in.data_hold_enable :
                     cfg_in.address_hold_enable);
    full_set = 1'b0;
    upd_set = 1'b0;

    // Software actions; hardware sets below win in the same cycle
    if (irq_clear_in)
      next_r.stat.serial_port_irq_flag = 1'b0;
    if (buf_read_in)
      next_r.stat.buffer_full_flag = 1'b0;
    if (ovf_clear_in)
      next_r.stat.receive_overflow_flag = 1'b0;
    if (clock_release_set_in)
      next_r.stat.clock_release_bit = 1'b1;
    if (own_addr_wr_in) begin
      next_r.own_address_reg = own_addr_in;
      next_r.stat.update_address_flag = 1'b0;
      next_r.upd_hold = 1'b0;
    end

    case (r.state)
      sar_pkg::ST_IDLE: begin
        next_r.cnt = 4'h0;
      end
      sar_pkg::ST_RECV: begin
        if (rise)
          next_r.cnt = r.cnt + 4'h1;
        if (fall8) begin
          if (!match) begin
            if (r.kind == sar_pkg::K_HI) begin
              next_r.state = sar_pkg::ST_IDLE;
              next_r.prior = 1'b0;
            end else begin
              next_r.lo_miss = 1'b1;
              next_r.sda_pull = 1'b0;
              next_r.state = sar_pkg::ST_ACK;
            end
          end else begin
            next_r.lo_miss = 1'b0;
            next_r.state = sar_pkg::ST_ACK;
            if (r.kind == sar_pkg::K_HI) begin
              next_r.stat.read_write = rx[0];
              if (!rx[0])
                next_r.prior = 1'b0;
            end
            if (!nack) begin
              next_r.stat.shift_buffer = rx;
              full_set = 1'b1;
            end
            if (r.stat.buffer_full_flag && !cfg_in.buffer_overwrite_enable)
              next_r.stat.receive_overflow_flag = 1'b1;
            if (hold) begin
              next_r.stat.serial_port_irq_flag = 1'b1;
              next_r.stat.clock_release_bit = 1'b0;
              next_r.stat.ack_phase_flag = 1'b1;
              next_r.sw_ack = 1'b1;
              next_r.sda_pull = 1'b0;
            end else begin
              next_r.sw_ack = 1'b0;
              next_r.sda_pull = !nack;
            end
          end
        end
      end
      sar_pkg::ST_ACK: begin
        if (r.sw_ack && !r.stat.clock_release_bit)
          next_r.sda_pull = !cfg_in.ack_value_select;
        if (rise)
          next_r.cnt = r.cnt + 4'h1;
        if (fall9) begin
          next_r.sda_pull = 1'b0;
          next_r.stat.ack_phase_flag = 1'b0;
          next_r.sw_ack = 1'b0;
          next_r.cnt = 4'h0;
          if (r.sda_pull)
            next_r.stat.serial_port_irq_flag = 1'b1;
          if (r.lo_miss) begin
            next_r.stat.serial_port_irq_flag = 1'b1;
            upd_set = 1'b1;
            next_r.state = sar_pkg::ST_IDLE;
          end else if (!r.sda_pull) begin
            next_r.state = sar_pkg::ST_IDLE;
          end else begin
            next_r.state = sar_pkg::ST_RECV;
            if (cfg_in.stretch_enable)
              next_r.stat.clock_release_bit = 1'b0;
            case (r.kind)
              sar_pkg::K_HI: begin
                if (r.stat.read_write) begin
                  next_r.stat.clock_release_bit = 1'b0;
                  next_r.state = sar_pkg::ST_WAIT;
                end else if (ten) begin
                  upd_set = 1'b1;
                  next_r.kind = sar_pkg::K_LO;
                end else begin
                  next_r.kind = sar_pkg::K_DATA;
                end
              end
              sar_pkg::K_LO: begin
                upd_set = 1'b1;
                next_r.prior = 1'b1;
                next_r.kind = sar_pkg::K_DATA;
              end
              default: begin
                next_r.kind = sar_pkg::K_DATA;
              end
            endcase
          end
        end
      end
      sar_pkg::ST_WAIT: begin
        next_r.cnt = 4'h0;
      end
      default: begin
        next_r.state = sar_pkg::ST_IDLE;
      end
    endcase

    if (full_set)
      next_r.stat.buffer_full_flag = 1'b1;
    if (upd_set) begin
      next_r.stat.update_address_flag = 1'b1;
      next_r.upd_hold = 1'b1;
    end

    // Start or restart resets the slave and awaits an address
    if (start_ev) begin
      next_r.state = sar_pkg::ST_RECV;
      next_r.kind = sar_pkg::K_HI;
      next_r.cnt = 4'h0;
      next_r.sda_pull = 1'b0;
      next_r.sw_ack = 1'b0;
      next_r.stat.ack_phase_flag = 1'b0;
      next_r.stat.start_detected = 1'b1;
      next_r.stat.stop_detected = 1'b0;
      if (sp_mode || cfg_in.start_irq_en)
        next_r.stat.serial_port_irq_flag = 1'b1;
    end
    if (stop_ev) begin
      next_r.state = sar_pkg::ST_IDLE;
      next_r.sda_pull = 1'b0;
      next_r.sw_ack = 1'b0;
      next_r.prior = 1'b0;
      next_r.stat.ack_phase_flag = 1'b0;
      next_r.stat.stop_detected = 1'b1;
      next_r.stat.start_detected = 1'b0;
      if (sp_mode || cfg_in.stop_irq_en)
        next_r.stat.serial_port_irq_flag = 1'b1;
    end
    next_r.scl_hold = !next_r.stat.clock_release_bit || next_r.upd_hold;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r <= '0;
      r.own_address_reg <= `SAR_OWN_RST;
      r.stat.clock_release_bit <= 1'b1;
      r.scl_s <= 3'h7;
      r.sda_s <= 3'h7;
    end else begin
      r <= next_r;
    end
  end

  assign scl_out = r.pin_low;
  assign sda_out = r.pin_low;
  assign scl_oe_out = r.scl_hold;
  assign sda_oe_out = r.sda_pull;
  assign status_out = r.stat;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  irq_sticky_a: assert property (
    status_out.serial_port_irq_flag && !irq_clear_in |=> status_out.serial_port_irq_flag)
    else $error("irq flag dropped without a clear");
  full_read_a: assert property (
    buf_read_in && !full_set |=> !status_out.buffer_full_flag)
    else $error("buffer read left buffer full set");
  addr_write_a: assert property (
    own_addr_wr_in && !upd_set |=> !status_out.update_address_flag)
    else $error("address write left update flag set");
  quiet_miss_a: assert property (
    fall8 && r.kind == sar_pkg::K_HI && !match && !status_out.serial_port_irq_flag
    |=> !status_out.serial_port_irq_flag && r.state == sar_pkg::ST_IDLE ##1 !sda_oe_out)
    else $error("address mismatch was signalled");
  start_seen_a: assert property (
    start_ev && cfg_in.start_irq_en
    |=> status_out.start_detected && status_out.serial_port_irq_flag)
    else $error("start not flagged");
  stop_idle_a: assert property (
    stop_ev |=> status_out.stop_detected && r.state == sar_pkg::ST_IDLE && !sda_oe_out)
    else $error("stop did not idle the slave");
  ack_slot_a: assert property (
    sda_oe_out |-> r.state == sar_pkg::ST_ACK)
    else $error("sda driven outside ack slot");
  overflow_nack_a: assert property (
    fall8 && match && !hold && status_out.buffer_full_flag &&
    !cfg_in.buffer_overwrite_enable |=> !sda_oe_out [*2])
    else $error("ack given while buffer full");
  hold_eighth_a: assert property (
    fall8 && hold |=> status_out.serial_port_irq_flag && scl_oe_out &&
    status_out.ack_phase_flag && !status_out.clock_release_bit)
    else $error("hold did not stretch after eighth bit");
  stretch_after_a: assert property (
    fall9 && r.sda_pull && !r.lo_miss && cfg_in.stretch_enable |=> ##1 scl_oe_out)
    else $error("no stretch after received byte");
  sw_ack_a: assert property (
    r.state == sar_pkg::ST_ACK && r.sw_ack && !r.stat.clock_release_bit && !fall9
    && !start_ev && !stop_ev |=> sda_oe_out == !$past(cfg_in.ack_value_select))
    else $error("ack slot ignores software ack value");
  ack_irq_a: assert property (
    fall9 && r.sda_pull |=> status_out.serial_port_irq_flag)
    else $error("no irq after an ack");
  nack_quiet_a: assert property (
    fall9 && !r.sda_pull && !r.lo_miss && !status_out.serial_port_irq_flag
    |=> !status_out.serial_port_irq_flag)
    else $error("irq raised after a nack");
  low_miss_a: assert property (
    fall9 && r.lo_miss |=> status_out.serial_port_irq_flag &&
    status_out.update_address_flag && scl_oe_out)
    else $error("low byte miss not flagged");
  ten_high_a: assert property (
    fall9 && r.sda_pull && r.kind == sar_pkg::K_HI && !r.stat.read_write && cfg_in.mode[0]
    |=> status_out.update_address_flag && scl_oe_out)
    else $error("high byte ack did not wait for low address");
  read_wait_a: assert property (
    fall9 && r.sda_pull && r.kind == sar_pkg::K_HI && r.stat.read_write
    |=> scl_oe_out && r.state == sar_pkg::ST_WAIT)
    else $error("read request did not hold the clock");
  data_load_a: assert property (
    fall8 && r.kind == sar_pkg::K_DATA && !nack
    |=> status_out.buffer_full_flag && status_out.shift_buffer == $past(rx))
    else $error("data byte not loaded");
  auto_ack_a: assert property (
    fall8 && match && !hold && !nack |=> sda_oe_out)
    else $error("matching byte not acked automatically");
endmodule

// [tb/sar_master.sv]
`timescale 1ns/1ps
module sar_master (
  // Wire levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Pulls, high = wire driven low
  output logic scl_low_out,
  output logic sda_low_out
);
  int stalls = 0;
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  // Release SCL and wait out any stretch
  task automatic scl_high();
    int n;
    n = 0;
    scl_low_out = 1'b0;
    #10;
    while (scl_in !== 1'b1 && n < 5000 && stalls == 0) begin
      #10;
      n++;
    end
    if (scl_in !== 1'b1) stalls++;
    #30;
  endtask
  // Start or restart
  task automatic start_cond();
    #3;
    sda_low_out = 1'b0;
    #40;
    scl_high();
    #40;
    sda_low_out = 1'b1;
    #80;
    scl_low_out = 1'b1;
    #40;
  endtask
  // Stop
  task automatic stop_cond();
    sda_low_out = 1'b1;
    #40;
    scl_high();
    #40;
    sda_low_out = 1'b0;
    #80;
  endtask
  // Eight bits MSB first, then sample the ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low_out = ~b[i];
      #40;
      scl_high();
      #40;
      scl_low_out = 1'b1;
      #40;
    end
    sda_low_out = 1'b0;
    #40;
    scl_high();
    ack = ~sda_in;
    #40;
    scl_low_out = 1'b1;
    #40;
  endtask
endmodule

// [tb/sar_slave_tb_top.sv]
`timescale 1ns/1ps
module sar_slave_tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  sar_pkg::sar_cfg_t cfg = '0;
  logic [7:0] own_addr = 8'h00;
  logic own_wr = 1'b0;
  logic rel_set = 1'b0;
  logic irq_clr = 1'b0;
  logic buf_rd = 1'b0;
  logic ovf_clr = 1'b0;
  logic scl_drv, scl_oe, sda_drv, sda_oe, m_scl_low, m_sda_low;
  sar_pkg::sar_status_t st;
  wire logic scl = ~(m_scl_low | scl_oe);
  wire logic sda = ~(m_sda_low | sda_oe);
  int mismatches = 0;
  int cmp_count = 0;
  initial forever #5 clk_in = ~clk_in;
  sar_slave i_sar_slave (
    .clk_in(clk_in), .rst_in(rst_in), .scl_clk_in(scl), .scl_in(scl), .scl_out(scl_drv),
    .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(sda_drv), .sda_oe_out(sda_oe),
    .cfg_in(cfg), .own_addr_in(own_addr), .own_addr_wr_in(own_wr),
    .clock_release_set_in(rel_set), .irq_clear_in(irq_clr), .buf_read_in(buf_rd),
    .ovf_clear_in(ovf_clr), .status_out(st)
  );
  sar_master i_sar_master (
    .scl_in(scl), .sda_in(sda), .scl_low_out(m_scl_low), .sda_low_out(m_sda_low)
  );
  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic flg(input logic got, input logic exp, input string what);
    chk({7'h00, got}, {7'h00, exp}, what);
  endtask
  // Strobes {own_wr, rel_set, irq_clr, buf_rd, ovf_clr}
  task automatic sw(input logic [4:0] s, input logic [7:0] a);
    @(negedge clk_in);
    own_addr = a;
    {own_wr, rel_set, irq_clr, buf_rd, ovf_clr} = s;
    @(negedge clk_in);
    {own_wr, rel_set, irq_clr, buf_rd, ovf_clr} = 5'h00;
    @(negedge clk_in);
  endtask
  task automatic byte_x(input logic [7:0] b, input logic exp_ack);
    logic ack;
    i_sar_master.send_byte(b, ack);
    repeat (6) @(negedge clk_in);
    flg(ack, exp_ack, "ack");
  endtask
  task automatic wait_hold();
    int n;
    n = 0;
    while (scl_oe !== 1'b1 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 200) begin
      mismatches++;
      $display("CHECK FAILED at %0t: SCL never held", $time);
      wrap_up();
    end
    repeat (3) @(negedge clk_in);
  endtask
  task automatic s_basic();
    @(negedge clk_in);
    cfg = '0;
    sw(5'h10, 8'h50);
    i_sar_master.start_cond();
    repeat (4) @(negedge clk_in);
    flg(st.start_detected, 1'b1, "start");
    flg(st.serial_port_irq_flag, 1'b0, "start irq");
    byte_x(8'h50, 1'b1);
    chk(st.shift_buffer, 8'h50, "addr");
    chk({1'b0, st[8:2]}, 8'h64, "addr flags");
    flg(scl_oe, 1'b0, "no stretch");
    sw(5'h06, 8'h50);
    flg(st.buffer_full_flag, 1'b0, "buffer read");
    byte_x(8'hA5, 1'b1);
    chk(st.shift_buffer, 8'hA5, "data");
    byte_x(8'h3C, 1'b0);
    chk(st.shift_buffer, 8'hA5, "kept");
    flg(st.receive_overflow_flag, 1'b1, "overflow");
    cfg.buffer_overwrite_enable = 1'b1;
    sw(5'h01, 8'h50);
    i_sar_master.start_cond();
    byte_x(8'h50, 1'b1);
    byte_x(8'hC3, 1'b1);
    chk(st.shift_buffer, 8'hC3, "overwrite");
    flg(st.receive_overflow_flag, 1'b0, "no overflow");
    i_sar_master.stop_cond();
    repeat (4) @(negedge clk_in);
    flg(st.stop_detected, 1'b1, "stop");
    flg(st.serial_port_irq_flag, 1'b1, "irq sticky");
    sw(5'h07, 8'h50);
  endtask
  task automatic s_addr();
    i_sar_master.start_cond();
    byte_x(8'h60, 1'b0);
    flg(st.serial_port_irq_flag | st.buffer_full_flag, 1'b0, "silent");
    i_sar_master.start_cond();
    byte_x(8'h51, 1'b1);
    flg(st.read_write, 1'b1, "read request");
    wait_hold();
    sw(5'h0E, 8'h50);
    i_sar_master.stop_cond();
  endtask
  task automatic s_stretch();
    @(negedge clk_in);
    cfg = '0;
    cfg.stretch_enable = 1'b1;
    i_sar_master.start_cond();
    byte_x(8'h50, 1'b1);
    wait_hold();
    flg(st.clock_release_bit, 1'b0, "stretch");
    sw(5'h0E, 8'h50);
    flg(scl_oe, 1'b0, "released");
    i_sar_master.stop_cond();
  endtask
  task automatic s_hold();
    logic ack;
    for (int v = 0; v < 2; v++) begin
      @(negedge clk_in);
      cfg = '0;
      cfg.address_hold_enable = 1'b1;
      cfg.data_hold_enable = 1'b1;
      cfg.ack_value_select = v[0];
      cfg.stretch_enable = 1'b1;
      i_sar_master.start_cond();
      fork
        i_sar_master.send_byte(8'h50, ack);
        begin
          wait_hold();
          flg(st.serial_port_irq_flag, 1'b1, "hold irq");
          flg(st.clock_release_bit, 1'b0, "hold clock");
          flg(st.ack_phase_flag, 1'b1, "ack phase");
          sw(5'h0E, 8'h50);
        end
      join
      repeat (6) @(negedge clk_in);
      flg(ack, ~v[0], "hold ack");
      flg(st.serial_port_irq_flag, ~v[0], "ninth irq");
      flg(scl_oe, ~v[0], "ack stretch");
      sw(5'h0E, 8'h50);
      i_sar_master.stop_cond();
    end
  endtask
  task automatic s_events();
    for (int m = 2; m < 5; m++) begin
      @(negedge clk_in);
      cfg = '0;
      cfg.mode = m[1:0];
      cfg.start_irq_en = (m == 4);
      cfg.stop_irq_en = (m == 4);
      i_sar_master.start_cond();
      repeat (4) @(negedge clk_in);
      flg(st.serial_port_irq_flag, 1'b1, "start irq");
      sw(5'h04, 8'h50);
      i_sar_master.stop_cond();
      repeat (4) @(negedge clk_in);
      flg(st.serial_port_irq_flag, 1'b1, "stop irq");
      sw(5'h04, 8'h50);
    end
  endtask
  task automatic s_ten(input logic [7:0] low);
    @(negedge clk_in);
    cfg = '0;
    cfg.mode = 2'h1;
    sw(5'h10, 8'h06);
    i_sar_master.start_cond();
    byte_x(8'hF6, 1'b1);
    wait_hold();
    flg(st.update_address_flag, 1'b1, "update high");
    sw(5'h1E, 8'h34);
    flg(st.update_address_flag, 1'b0, "update cleared");
    byte_x(low, low == 8'h34);
    wait_hold();
    flg(st.update_address_flag & st.serial_port_irq_flag, 1'b1, "update low");
    flg(st.buffer_full_flag, low == 8'h34, "low buffer");
    sw(5'h1E, 8'h06);
    if (low == 8'h34) begin
      byte_x(8'h5A, 1'b1);
      chk(st.shift_buffer, 8'h5A, "ten data");
    end
    i_sar_master.stop_cond();
    sw(5'h07, 8'h06);
  endtask
  initial begin
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk(st[7:0], 8'h10, "reset flags");
    flg(scl_oe | sda_oe, 1'b0, "reset pins");
    flg(scl_drv | sda_drv, 1'b0, "pin data low");
    s_basic();
    s_addr();
    s_stretch();
    s_hold();
    s_events();
    s_ten(8'h35);
    s_ten(8'h34);
    flg(i_sar_master.stalls == 0, 1'b1, "bus stalled");
    wrap_up();
  end
endmodule
